//--- usbsr_pkg.sv
package usbsr_pkg;
  // Clock rate and derived cycle counts
  localparam int CLK_HZ            = 20000000;
  localparam int IDLE_SUSP_US      = 3000;
  localparam int CLK_STOP_US       = 2000;
  localparam int MIN_SUSP_US       = 5000;
  localparam int RESUME_US         = 5000;
  localparam int RESUME_FAST_US    = 100;
  localparam int REMOTE_K_US       = 10000;
  localparam int IDLE_SUSP_CYC     = IDLE_SUSP_US * (CLK_HZ / 1000000);
  localparam int CLK_STOP_CYC      = CLK_STOP_US * (CLK_HZ / 1000000);
  localparam int MIN_SUSP_CYC      = MIN_SUSP_US * (CLK_HZ / 1000000);
  localparam int RESUME_CYC        = RESUME_US * (CLK_HZ / 1000000);
  localparam int RESUME_FAST_CYC   = RESUME_FAST_US * (CLK_HZ / 1000000);
  localparam int REMOTE_K_CYC      = REMOTE_K_US * (CLK_HZ / 1000000);
  localparam int OSC_STABLE_CYC    = 64;
  localparam int CNT_W             = 24;

  // Power state machine
  typedef enum logic [2:0] {
    USBSR_RUN   = 3'b000,
    USBSR_SUSP  = 3'b001,
    USBSR_STAB  = 3'b010,
    USBSR_WAKE  = 3'b011
  } usbsr_state_t;

  // Firmware-facing configuration bits
  typedef struct packed {
    logic suspend_irq_enable;
    logic resume_irq_enable;
    logic clock_keep_running;
    logic wake_on_select;
    logic enter_suspend_cmd;
  } usbsr_cfg_t;

  // Status bits shown to firmware
  typedef struct packed {
    logic suspend_flag;
    logic resume_flag;
    logic bus_state_flag;
  } usbsr_stat_t;
endpackage

//--- usbsr_ctrl.sv
`timescale 1ns/1ps
module usbsr_ctrl
  import usbsr_pkg::*;
#(
  parameter int CYC_PER_US = CLK_HZ / 1000000
)
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire usbsr_cfg_t  cfg,
  input  wire logic        sof_pulse,
  input  wire logic        bus_idle,
  input  wire logic        vbus_present,
  input  wire logic        bus_k_state,
  input  wire logic        bus_traffic,
  input  wire logic        cs_n,
  input  wire logic        wake_pin_in,
  input  wire logic        fast_timing_pin,
  input  wire logic        osc_stable,
  input  wire logic        unlock_cmd,
  input  wire logic        suspend_flag_clr,
  input  wire logic        resume_flag_clr,
  output logic             irq,
  output usbsr_stat_t      status,
  output logic             suspend_wake_pin_out,
  output logic             suspend_wake_pin_oe,
  output logic             osc_enable,
  output logic             clk_gate_en,
  output logic             drive_k_state,
  output logic             reg_locked
);

  // Interval lengths in core cycles; a faster tick only shortens the waits
  localparam int IDLE_SUSP_CYC   = IDLE_SUSP_US * CYC_PER_US;
  localparam int CLK_STOP_CYC    = CLK_STOP_US * CYC_PER_US;
  localparam int MIN_SUSP_CYC    = MIN_SUSP_US * CYC_PER_US;
  localparam int RESUME_CYC      = RESUME_US * CYC_PER_US;
  localparam int RESUME_FAST_CYC = RESUME_FAST_US * CYC_PER_US;
  localparam int REMOTE_K_CYC    = REMOTE_K_US * CYC_PER_US;

  // Two-stage synchronisers for the asynchronous pins
  logic [5:0] sync1_reg, sync2_reg;
  logic [5:0] async_in;
  assign async_in = {vbus_present, bus_k_state, bus_traffic, cs_n, wake_pin_in, fast_timing_pin};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Idle levels of the pins, so no false edge or wake after reset
      sync1_reg <= 6'h27;
      sync2_reg <= 6'h27;
    end else if (clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic vbus_s, k_s, traffic_s, cs_n_s, wpin_s, fast_s;
  assign {vbus_s, k_s, traffic_s, cs_n_s, wpin_s, fast_s} = sync2_reg;

  usbsr_state_t     state_reg, state_next;
  logic [CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
  logic [CNT_W-1:0] tmr_reg, tmr_next;
  logic [CNT_W-1:0] k_cnt_reg, k_cnt_next;
  logic             enter_suspend_cmd_seen_reg, enter_suspend_cmd_seen_next;
  logic             susp_flag_reg, susp_flag_next;
  logic             res_flag_reg, res_flag_next;
  logic             bus_idle_reg, bus_idle_next;
  logic             pin_hi_reg, pin_hi_next;
  logic             clk_on_reg, clk_on_next;
  logic             osc_reg, osc_next;
  logic             lock_reg, lock_next;
  logic             remote_reg, remote_next;
  logic             wpin_d_reg, cs_d_reg;
  logic             irq_reg, irq_next;
  logic             wake_host, wake_app, idle_hit;

  // Wake pin and chip select wake on falling edges, host wake on K or traffic level, all from the second synchroniser stage
  assign wake_app  = (wpin_d_reg & ~wpin_s) | (cfg.wake_on_select & cs_d_reg & ~cs_n_s);
  assign wake_host = k_s | traffic_s;
  assign idle_hit  = (idle_cnt_reg == CNT_W'(IDLE_SUSP_CYC - 1)) & bus_idle & ~sof_pulse;

  // Next-state logic for the whole controller
  always_comb begin
    state_next       = state_reg;
    idle_cnt_next    = idle_cnt_reg;
    tmr_next         = tmr_reg;
    k_cnt_next       = k_cnt_reg;
    enter_suspend_cmd_seen_next = enter_suspend_cmd_seen_reg;
    susp_flag_next   = susp_flag_reg;
    res_flag_next    = res_flag_reg;
    bus_idle_next    = bus_idle_reg;
    pin_hi_next      = pin_hi_reg;
    clk_on_next      = clk_on_reg;
    osc_next         = osc_reg;
    lock_next        = lock_reg;
    remote_next      = remote_reg;
    // Clear first so a same-cycle set wins
    if (suspend_flag_clr) begin
      susp_flag_next = 1'b0;
    end
    if (resume_flag_clr) begin
      res_flag_next = 1'b0;
    end
    if (unlock_cmd) begin
      lock_next = 1'b0;
    end
    // idle counter, restarted by any start-of-frame or activity
    if (sof_pulse || !bus_idle) begin
      idle_cnt_next = '0;
      bus_idle_next = 1'b0;
    end else if (idle_cnt_reg != CNT_W'(IDLE_SUSP_CYC)) begin
      // Runs one past the hit so the flag is set once and can be cleared
      idle_cnt_next = idle_cnt_reg + CNT_W'(1);
    end
    // suspend flag on 3 ms idle or lost bus power
    if (state_reg == USBSR_RUN && (idle_hit || (!vbus_s && bus_idle_reg == 1'b0))) begin
      susp_flag_next = 1'b1;
      bus_idle_next  = 1'b1;
    end
    unique case (state_reg)
      USBSR_RUN: begin
        if (cfg.enter_suspend_cmd) begin
          enter_suspend_cmd_seen_next = 1'b1;
        end else if (enter_suspend_cmd_seen_reg) begin
          enter_suspend_cmd_seen_next = 1'b0;
          state_next       = USBSR_SUSP;
          tmr_next         = '0;
          pin_hi_next      = 1'b1;
        end
      end
      USBSR_SUSP: begin
        if (tmr_reg != CNT_W'(MIN_SUSP_CYC - 1)) begin
          tmr_next = tmr_reg + CNT_W'(1);
        end
        // clocks stop 2 ms after entry unless kept running
        if (tmr_reg == CNT_W'(CLK_STOP_CYC - 1) && !cfg.clock_keep_running) begin
          clk_on_next = 1'b0;
          osc_next    = 1'b0;
        end
        // wake only after minimum suspend time
        if (tmr_reg == CNT_W'(MIN_SUSP_CYC - 1) && (wake_host || wake_app)) begin
          state_next  = USBSR_STAB;
          remote_next = wake_app & ~wake_host;
          tmr_next    = '0;
          osc_next    = 1'b1;
        end
      end
      USBSR_STAB: begin
        tmr_next = tmr_reg + CNT_W'(1);
        if (osc_stable && tmr_reg >= CNT_W'(OSC_STABLE_CYC - 1)) begin
          clk_on_next   = 1'b1;
          state_next    = USBSR_WAKE;
          pin_hi_next   = 1'b0;
          res_flag_next = 1'b1;
          lock_next     = 1'b1;
          k_cnt_next    = remote_reg ? CNT_W'(REMOTE_K_CYC) : '0;
        end
      end
      USBSR_WAKE: begin
        tmr_next = tmr_reg + CNT_W'(1);
        // resume delay, short with fast timing
        if (tmr_reg >= CNT_W'((fast_s ? RESUME_FAST_CYC : RESUME_CYC) - 1)) begin
          state_next    = USBSR_RUN;
          idle_cnt_next = '0;
        end
      end
      default: state_next = USBSR_RUN;
    endcase
    if (k_cnt_reg != '0) begin
      k_cnt_next = k_cnt_reg - CNT_W'(1);
    end
    irq_next = (susp_flag_next & cfg.suspend_irq_enable) | (res_flag_next & cfg.resume_irq_enable);
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg       <= USBSR_RUN;
      idle_cnt_reg    <= '0;
      tmr_reg         <= '0;
      k_cnt_reg       <= '0;
      enter_suspend_cmd_seen_reg <= 1'b0;
      susp_flag_reg   <= 1'b0;
      res_flag_reg    <= 1'b0;
      bus_idle_reg    <= 1'b0;
      pin_hi_reg      <= 1'b0;
      clk_on_reg      <= 1'b1;
      osc_reg         <= 1'b1;
      lock_reg        <= 1'b0;
      remote_reg      <= 1'b0;
      wpin_d_reg      <= 1'b1;
      cs_d_reg        <= 1'b1;
      irq_reg         <= 1'b0;
    end else if (clk_en) begin
      state_reg       <= state_next;
      idle_cnt_reg    <= idle_cnt_next;
      tmr_reg         <= tmr_next;
      k_cnt_reg       <= k_cnt_next;
      enter_suspend_cmd_seen_reg <= enter_suspend_cmd_seen_next;
      susp_flag_reg   <= susp_flag_next;
      res_flag_reg    <= res_flag_next;
      bus_idle_reg    <= bus_idle_next;
      pin_hi_reg      <= pin_hi_next;
      clk_on_reg      <= clk_on_next;
      osc_reg         <= osc_next;
      lock_reg        <= lock_next;
      remote_reg      <= remote_next;
      wpin_d_reg      <= wpin_s;
      cs_d_reg        <= cs_n_s;
      irq_reg         <= irq_next;
    end
  end

  // Outputs from flip-flops, drive_k_state decoded from the K counter; pin driven only while high
  assign irq                  = irq_reg;
  assign status               = '{susp_flag_reg, res_flag_reg, ~bus_idle_reg};
  assign suspend_wake_pin_out = pin_hi_reg;
  assign suspend_wake_pin_oe  = pin_hi_reg;
  assign osc_enable           = osc_reg;
  assign clk_gate_en          = clk_on_reg;
  assign drive_k_state        = (k_cnt_reg != '0);
  assign reg_locked           = lock_reg;

  suspend_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && state_reg == USBSR_RUN && idle_hit |=> susp_flag_reg)
    else $error("suspend flag not set after idle");
  enter_susp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == USBSR_RUN && state_next == USBSR_SUSP |-> enter_suspend_cmd_seen_reg && !cfg.enter_suspend_cmd)
    else $error("suspend entered without set-clear");
  pin_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && state_reg == USBSR_SUSP |-> pin_hi_reg)
    else $error("wake pin low in suspend");
  min_susp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == USBSR_SUSP && state_next == USBSR_STAB |-> tmr_reg == CNT_W'(MIN_SUSP_CYC - 1))
    else $error("woke before minimum suspend");
  cs_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == USBSR_SUSP && state_next == USBSR_STAB && !cfg.wake_on_select |->
      wake_host || (wpin_d_reg && !wpin_s))
    else $error("chip select woke while disabled");
  clk_stable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(clk_on_reg) |-> $past(osc_stable) && osc_reg)
    else $error("clocks given before stable");
  resume_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && state_reg == USBSR_STAB && state_next == USBSR_WAKE |=> res_flag_reg && !pin_hi_reg)
    else $error("resume flag or pin wrong");
  lock_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && state_reg == USBSR_STAB && state_next == USBSR_WAKE |=> reg_locked)
    else $error("registers not locked after wake");

endmodule // usbsr_ctrl

//--- usbsr_far_model.sv
`timescale 1ns/1ps
// Far side: host frame timing and the external oscillator
module usbsr_far_model #(
  parameter int FRAME_CYC = 20000
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       idle_req,
  input  wire logic       osc_enable,
  input  wire logic [7:0] osc_delay,
  output logic            bus_idle,
  output logic            sof_pulse,
  output logic            osc_stable
);
  int frame_cnt = 0;
  int osc_cnt   = 0;
  initial begin
    bus_idle   = 1'b0;
    sof_pulse  = 1'b0;
    osc_stable = 1'b0;
  end
  // One frame marker per ms while active; an idle bus sends none
  always @(negedge core_clk) begin
    frame_cnt = (sys_rst || idle_req) ? 0 : (frame_cnt + 1) % FRAME_CYC;
    bus_idle  <= idle_req;
    sof_pulse <= !sys_rst && !idle_req && frame_cnt == 1;
  end
  // Settles a random time after enable, so no fixed latency is assumed
  always @(negedge core_clk) begin
    osc_cnt    = osc_enable ? osc_cnt + 1 : 0;
    osc_stable <= osc_enable && osc_cnt > osc_delay;
  end
endmodule // usbsr_far_model

//--- tb_usbsr_ctrl.sv
`timescale 1ns/1ps
module tb_usbsr_ctrl;
  import usbsr_pkg::*;
  // One cycle per microsecond keeps the run short; ratios stay as built
  localparam int TB_US           = 1;
  localparam int IDLE_SUSP_CYC   = IDLE_SUSP_US * TB_US;
  localparam int CLK_STOP_CYC    = CLK_STOP_US * TB_US;
  localparam int MIN_SUSP_CYC    = MIN_SUSP_US * TB_US;
  localparam int RESUME_FAST_CYC = RESUME_FAST_US * TB_US;
  localparam int REMOTE_K_CYC    = REMOTE_K_US * TB_US;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, idle_req = 0, app_low = 0;
  logic vbus_present = 1, bus_k_state = 0, bus_traffic = 0, cs_n = 1, fast_timing_pin = 1;
  logic unlock_cmd = 0, suspend_flag_clr = 0, resume_flag_clr = 0;
  logic bus_idle, sof_pulse, osc_stable, irq, pin_out, pin_oe, osc_enable, clk_gate_en;
  logic drive_k_state, reg_locked, wake_pin_in;
  logic [7:0] osc_delay;
  usbsr_cfg_t cfg = 5'b11000;
  usbsr_stat_t status;
  int seed = 58, error_cnt = 0, total_checks = 0, n;
  // Application pull-down wins over the device's drive
  assign wake_pin_in = app_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  always #25 core_clk = ~core_clk;
  usbsr_far_model #(.FRAME_CYC(1000 * TB_US)) far (.core_clk(core_clk), .sys_rst(sys_rst),
    .idle_req(idle_req),
    .osc_enable(osc_enable), .osc_delay(osc_delay), .bus_idle(bus_idle),
    .sof_pulse(sof_pulse), .osc_stable(osc_stable));
  usbsr_ctrl #(.CYC_PER_US(TB_US)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cfg(cfg),
    .sof_pulse(sof_pulse), .bus_idle(bus_idle), .vbus_present(vbus_present),
    .bus_k_state(bus_k_state), .bus_traffic(bus_traffic), .cs_n(cs_n),
    .wake_pin_in(wake_pin_in), .fast_timing_pin(fast_timing_pin), .osc_stable(osc_stable),
    .unlock_cmd(unlock_cmd), .suspend_flag_clr(suspend_flag_clr),
    .resume_flag_clr(resume_flag_clr), .irq(irq), .status(status),
    .suspend_wake_pin_out(pin_out), .suspend_wake_pin_oe(pin_oe), .osc_enable(osc_enable),
    .clk_gate_en(clk_gate_en), .drive_k_state(drive_k_state), .reg_locked(reg_locked));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return status.suspend_flag;
      1: return !clk_gate_en;
      2: return status.resume_flag;
      default: return osc_enable;
    endcase
  endfunction
  // Bounded wait; running out ends the run as a failure
  task automatic wait_sig(input int w, input int lim, output int cnt);
    cnt = 0;
    while (pick(w) !== 1'b1 && cnt < lim) begin
      cyc(1);
      cnt++;
    end
    if (cnt == lim) begin
      error_cnt++;
      close_out;
    end
  endtask
  task automatic clr_flags;
    suspend_flag_clr = 1;
    resume_flag_clr = 1;
    cyc(1);
    suspend_flag_clr = 0;
    resume_flag_clr = 0;
    cyc(2);
  endtask
  initial begin
    osc_delay = 8'($random(seed));
    repeat (4) @(negedge core_clk);
    sys_rst = 0;
    chk({irq, status, pin_out, pin_oe, osc_enable, clk_gate_en, drive_k_state, reg_locked},
        10'b00_0100_1100);
    cyc(3);
    // Idle bus with no frames raises the suspend flag and interrupt
    idle_req = 1;
    cyc(1);
    wait_sig(0, IDLE_SUSP_CYC + 10, n);
    chk(n >= IDLE_SUSP_CYC - 3 && n <= IDLE_SUSP_CYC + 3, 1);
    chk(irq, 1);
    chk(status.bus_state_flag, 0);
    clr_flags;
    // Set, still held: no suspend yet; then clear enters it
    cfg.enter_suspend_cmd = 1;
    cyc(4);
    chk(pin_oe, 0);
    cfg.enter_suspend_cmd = 0;
    cyc(3);
    chk({pin_oe, pin_out}, 2'b11);
    wait_sig(1, CLK_STOP_CYC + 10, n);
    chk(n >= CLK_STOP_CYC - 5, 1);
    // Early wake pulse falls inside the minimum suspend time
    cyc(CLK_STOP_CYC / 2);
    app_low = 1;
    cyc(4);
    app_low = 0;
    cyc(10);
    chk({osc_enable, pin_oe}, 2'b01);
    cyc(MIN_SUSP_CYC);
    // Chip select must not wake while its wake enable is off
    cs_n = 0;
    cyc(4);
    cs_n = 1;
    cyc(10);
    chk(osc_enable, 0);
    cfg.wake_on_select = 1;
    idle_req = 0;
    cs_n = 0;
    cyc(4);
    cs_n = 1;
    wait_sig(3, 20, n);
    chk(clk_gate_en, 0);
    wait_sig(2, 600, n);
    chk(n + 4 >= OSC_STABLE_CYC && n + 4 >= int'(osc_delay), 1);
    chk({clk_gate_en, pin_out, irq}, 3'b101);
    chk({drive_k_state, reg_locked}, 2'b11);
    clr_flags;
    chk(irq, 0);
    cyc(RESUME_FAST_CYC + 10);
    chk(reg_locked, 1);
    // Firmware unlocks after wake
    unlock_cmd = 1;
    cyc(1);
    unlock_cmd = 0;
    cyc(2);
    chk(reg_locked, 0);
    cyc(REMOTE_K_CYC);
    chk(drive_k_state, 0);
    clr_flags;
    vbus_present = 0;
    wait_sig(0, 10, n);
    chk(status.suspend_flag, 1);
    close_out;
  end
endmodule // tb_usbsr_ctrl
